// ===== pkg/vmf_pkg.sv
// Package for the virtual memory fault status block.
package vmf_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_MASK = 12'h004;
    localparam logic [11:0] ADDR_LOCK = 12'h008;
    localparam logic [11:0] ADDR_CTRL = 12'h00c;
    localparam logic [11:0] ADDR_BUFMAX = 12'h010;
    localparam logic [11:0] ADDR_MAPSIZE = 12'h014;
    localparam logic [11:0] ADDR_EVENT = 12'h018;
    localparam logic [11:0] ADDR_EVMASK = 12'h01c;
    localparam logic [11:0] ADDR_CACHEFLT = 12'h020;

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    localparam int STAT_W = 17;
    localparam int BIT_WR_NONREC = 11;
    localparam int BIT_WR_REC = 10;
    localparam int BIT_RD_FAULT = 9;
    localparam int BIT_ABOVE_MAX = 8;
    localparam int BIT_OUT_MAP = 7;
    localparam logic [16:0] STAT_RESET = 17'h00000;
    localparam logic [16:0] STAT_IMPL = 17'h00f80;

    // Event bits.
    localparam int EV_W = 3;
    localparam int EV_SCHED = 0;
    localparam int EV_DROP = 1;
    localparam int EV_READMAP = 2;

    // Small-copy read fault window and full-word byte enable.
    localparam logic [31:0] SEG_HEAD_BYTES = 32'h00000020;
    localparam logic [3:0] FULL_WORD_BE = 4'hf;

    localparam logic [31:0] BUFMAX_RESET = 32'h0000ffff;
    localparam logic [31:0] MAPSIZE_RESET = 32'h00010000;
    localparam logic [31:0] SEG_SIZE = 32'h00000800;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        REQ_CACHE_DMA = 3'h0,
        REQ_REASSEMBLY = 3'h1,
        REQ_SCHEDULER = 3'h2,
        REQ_OTHER = 3'h3
    } vmf_req_t;

    typedef enum logic [1:0]
    {
        FAIL_SEND = 2'h0,
        FAIL_FREE = 2'h1,
        FAIL_EVENT = 2'h2
    } vmf_fail_act_t;

    typedef enum logic [1:0]
    {
        SCH_IDLE = 2'h0,
        SCH_CHECK = 2'h1,
        SCH_ACT = 2'h2
    } vmf_sch_state_t;

    // One virtual memory access as reported by the mapping logic.
    typedef struct packed
    {
        logic valid;
        logic write;
        vmf_req_t req;
        logic [31:0] vaddr;
        logic [3:0] be;
        logic page_fault;
        logic predictive;
        logic cached_reread;
        logic [15:0] frame_id;
    } vmf_access_t;

    // A frame enqueued to the transmit scheduler.
    typedef struct packed
    {
        logic valid;
        logic [15:0] frame_id;
        logic hdr_failed;
    } vmf_frame_t;

endpackage

// ===== src/vmf_fail_mem.sv
// Memory of per-frame DMA failure marks, kept apart from the packet header flags.
`timescale 1ns/10ps

module vmf_fail_mem #(
    parameter int DEPTH = 64
)(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Write port.
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic wr_data,
    // Read port with registered data.
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic rd_data
);

    logic [DEPTH-1:0] mem;

    initial
    begin
        if (DEPTH < 2)
        begin
            $error("vmf_fail_mem: DEPTH must be at least 2");
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem <= '0;
            rd_data <= 1'b0;
        end
        else
        begin
            if (wr_en)
            begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ===== src/vmf_status.sv
// Virtual memory fault detection, status flags and failure handling.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module vmf_status #(
    parameter int FRAMES = 64
)(
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Access reports from the mapping logic.
    input wire vmf_pkg::vmf_access_t acc,
    // Frames enqueued to the transmit scheduler.
    input wire vmf_pkg::vmf_frame_t frame_in,
    // Actions toward the rest of the adapter.
    output logic seg_valid,
    output logic [15:0] seg_frame,
    output logic free_valid,
    output logic [15:0] free_frame,
    output logic rx_drop,
    output logic map_page,
    output logic halt_read,
    output logic irq
);
    import vmf_pkg::*;

    localparam int AW = $clog2(FRAMES);
    // Offset bits of an address within one virtual segment.
    localparam int SEG_OFS_W = $clog2(SEG_SIZE);

    initial
    begin
        if (FRAMES < 2 || FRAMES > 65536 || (FRAMES & (FRAMES - 1)) != 0)
        begin
            $error("vmf_status: FRAMES out of range");
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [16:0] status;
    logic [16:0] mask;
    logic [16:0] lock;
    vmf_fail_act_t fail_act;
    logic [31:0] bufmax;
    logic [31:0] mapsize;
    logic [2:0] events;
    logic [2:0] evmask;
    logic [31:0] read_mux;

    function automatic logic [31:0] pad17(input logic [16:0] v);
        pad17 = {15'h0000, v};
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire bus_wr = psel && penable && pwrite;
    wire bus_setup = psel && !penable;
    wire wr_status = bus_wr && (paddr == ADDR_STATUS);
    wire wr_mask = bus_wr && (paddr == ADDR_MASK);
    wire wr_lock = bus_wr && (paddr == ADDR_LOCK);
    wire wr_ctrl = bus_wr && (paddr == ADDR_CTRL);
    wire wr_bufmax = bus_wr && (paddr == ADDR_BUFMAX);
    wire wr_mapsize = bus_wr && (paddr == ADDR_MAPSIZE);
    wire wr_event = bus_wr && (paddr == ADDR_EVENT);
    wire wr_evmask = bus_wr && (paddr == ADDR_EVMASK);
    wire addr_hit = (paddr == ADDR_STATUS) || (paddr == ADDR_MASK)
        || (paddr == ADDR_LOCK) || (paddr == ADDR_CTRL) || (paddr == ADDR_BUFMAX)
        || (paddr == ADDR_MAPSIZE) || (paddr == ADDR_EVENT)
        || (paddr == ADDR_EVMASK) || (paddr == ADDR_CACHEFLT);

    // ------------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------------
    wire recov_req = (acc.req == REQ_CACHE_DMA) || (acc.req == REQ_REASSEMBLY);
    wire wr_fault = acc.valid && acc.write && acc.page_fault;
    wire set_nonrec = wr_fault && !recov_req;
    wire set_rec = wr_fault && recov_req;
    wire small_reread = acc.cached_reread && (acc.be != FULL_WORD_BE)
        && (acc.vaddr[SEG_OFS_W-1:0] < SEG_HEAD_BYTES[SEG_OFS_W-1:0]);
    wire rd_fault = acc.valid && !acc.write
        && (acc.page_fault || acc.predictive || small_reread);
    wire above_max = acc.valid && (acc.vaddr > bufmax);
    wire out_map = acc.valid && (acc.vaddr >= mapsize);

    logic [16:0] det;
    always_comb
    begin
        det = '0;
        det[BIT_WR_NONREC] = set_nonrec;
        det[BIT_WR_REC] = set_rec;
        det[BIT_RD_FAULT] = rd_fault;
        det[BIT_ABOVE_MAX] = above_max;
        det[BIT_OUT_MAP] = out_map;
    end

    // Set wins over a write-one clear in the same cycle.
    wire [16:0] next_status = ((status & ~(wr_status ? pwdata[16:0] : 17'h00000)) | det)
        & STAT_IMPL;

    wire rx_fault = set_rec && (acc.req == REQ_REASSEMBLY);
    wire dma_fault = set_rec && (acc.req == REQ_CACHE_DMA);
    wire read_map = rd_fault && !lock[BIT_RD_FAULT];

    // ------------------------------------------------------------------
    // Failure marks and transmit scheduler
    // ------------------------------------------------------------------
    vmf_sch_state_t sch_state;
    vmf_sch_state_t next_sch;
    logic [15:0] sch_frame;
    logic mark_rd;

    wire mark_clr = (sch_state == SCH_IDLE) && frame_in.valid;
    wire mark_wr = dma_fault || mark_clr;
    wire [AW-1:0] mark_addr = dma_fault ? acc.frame_id[AW-1:0] : frame_in.frame_id[AW-1:0];

    vmf_fail_mem #(
        .DEPTH(FRAMES)
    ) u_marks (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mark_wr),
        .wr_addr(mark_addr),
        .wr_data(dma_fault),
        .rd_addr(frame_in.frame_id[AW-1:0]),
        .rd_data(mark_rd)
    );

    logic hdr_flag;
    wire frame_failed = hdr_flag || mark_rd;

    always_comb
    begin
        case (sch_state)
            SCH_IDLE: next_sch = frame_in.valid ? SCH_CHECK : SCH_IDLE;
            SCH_CHECK: next_sch = SCH_ACT;
            SCH_ACT: next_sch = SCH_IDLE;
            default: next_sch = SCH_IDLE;
        endcase
    end

    wire act_now = (sch_state == SCH_CHECK);
    wire send_now = act_now && (!frame_failed || fail_act == FAIL_SEND);
    wire free_now = act_now && frame_failed && (fail_act == FAIL_FREE);
    wire event_now = act_now && frame_failed && (fail_act == FAIL_EVENT);

    logic [2:0] ev_det;
    always_comb
    begin
        ev_det = '0;
        ev_det[EV_SCHED] = event_now;
        ev_det[EV_DROP] = rx_fault;
        ev_det[EV_READMAP] = read_map;
    end
    wire [2:0] next_events = (events & ~(wr_event ? pwdata[2:0] : 3'h0)) | ev_det;

    always_comb
    begin
        case (paddr)
            ADDR_STATUS: read_mux = pad17(status);
            ADDR_MASK: read_mux = pad17(mask);
            ADDR_LOCK: read_mux = pad17(lock);
            ADDR_CTRL: read_mux = {30'h00000000, fail_act};
            ADDR_BUFMAX: read_mux = bufmax;
            ADDR_MAPSIZE: read_mux = mapsize;
            ADDR_EVENT: read_mux = {29'h00000000, events};
            ADDR_EVMASK: read_mux = {29'h00000000, evmask};
            default: read_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status <= STAT_RESET;
            mask <= '0;
            lock <= '0;
            fail_act <= FAIL_FREE;
            bufmax <= BUFMAX_RESET;
            mapsize <= MAPSIZE_RESET;
            events <= '0;
            evmask <= '0;
        end
        else
        begin
            status <= next_status;
            events <= next_events;
            if (wr_mask) mask <= pwdata[16:0] & STAT_IMPL;
            if (wr_lock) lock <= pwdata[16:0] & STAT_IMPL;
            if (wr_ctrl) fail_act <= vmf_fail_act_t'(pwdata[1:0]);
            if (wr_bufmax) bufmax <= pwdata;
            if (wr_mapsize) mapsize <= pwdata;
            if (wr_evmask) evmask <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sch_state <= SCH_IDLE;
            sch_frame <= '0;
            hdr_flag <= 1'b0;
        end
        else
        begin
            sch_state <= next_sch;
            if (mark_clr)
            begin
                sch_frame <= frame_in.frame_id;
                hdr_flag <= frame_in.hdr_failed;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            seg_valid <= 1'b0;
            seg_frame <= '0;
            free_valid <= 1'b0;
            free_frame <= '0;
            rx_drop <= 1'b0;
            map_page <= 1'b0;
            halt_read <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            pready <= bus_setup;
            pslverr <= bus_setup && !addr_hit;
            prdata <= (bus_setup && !pwrite) ? read_mux : 32'h00000000;
            seg_valid <= send_now;
            seg_frame <= sch_frame;
            free_valid <= free_now;
            free_frame <= sch_frame;
            rx_drop <= rx_fault;
            map_page <= read_map;
            halt_read <= rd_fault && lock[BIT_RD_FAULT];
            irq <= (|(next_status & mask)) || (|(next_events & evmask));
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_NONREC: assert property (@(posedge pclk) disable iff (!presetn)
        set_nonrec |=> status[BIT_WR_NONREC])
        else $error("write fault did not set bit 11");
    AST_REC_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fault && recov_req && !status[BIT_WR_NONREC] && !set_nonrec)
        |=> !status[BIT_WR_NONREC])
        else $error("recoverable fault set bit 11");
    AST_REC: assert property (@(posedge pclk) disable iff (!presetn)
        set_rec |=> status[BIT_WR_REC])
        else $error("recoverable fault did not set bit 10");
    AST_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        rx_fault |=> rx_drop)
        else $error("reassembly fault did not drop packet");
    AST_RDF: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fault |=> status[BIT_RD_FAULT])
        else $error("read fault did not set bit 9");
    AST_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_fault && !lock[BIT_RD_FAULT]) |=> (map_page && !halt_read))
        else $error("unlocked read fault did not map page");
    AST_MAX: assert property (@(posedge pclk) disable iff (!presetn)
        above_max |=> status[BIT_ABOVE_MAX])
        else $error("above maximum did not set bit 8");
    AST_MAPOUT: assert property (@(posedge pclk) disable iff (!presetn)
        out_map |=> status[BIT_OUT_MAP])
        else $error("outside map did not set bit 7");
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (status[BIT_OUT_MAP] && !wr_status) |=> status[BIT_OUT_MAP])
        else $error("flag cleared without software");
    AST_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (act_now && frame_failed && fail_act != FAIL_SEND) |=> !seg_valid)
        else $error("failed frame passed to segmentation");
    AST_FREE: assert property (@(posedge pclk) disable iff (!presetn)
        (act_now && frame_failed && fail_act == FAIL_FREE) |=> free_valid)
        else $error("failed frame not freed");
    AST_SEND: assert property (@(posedge pclk) disable iff (!presetn)
        (act_now && frame_failed && fail_act == FAIL_SEND) |=> seg_valid)
        else $error("failed frame not sent when configured to send");
    AST_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (act_now && frame_failed && fail_act == FAIL_EVENT)
        |=> (events[EV_SCHED] && !seg_valid && !free_valid))
        else $error("failed frame did not raise an event");
    AST_CLEAN: assert property (@(posedge pclk) disable iff (!presetn)
        (act_now && !frame_failed) |=> (seg_valid && !free_valid))
        else $error("clean frame not passed to segmentation");
    AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_fault && lock[BIT_RD_FAULT]) |=> (halt_read && !map_page))
        else $error("locked read fault mapped a page");
    AST_PREDICT: assert property (@(posedge pclk) disable iff (!presetn)
        (acc.valid && !acc.write && acc.predictive) |=> status[BIT_RD_FAULT])
        else $error("predictive read did not set bit 9");
    AST_SMALL: assert property (@(posedge pclk) disable iff (!presetn)
        (acc.valid && !acc.write && small_reread) |=> status[BIT_RD_FAULT])
        else $error("small copy re-read did not set bit 9");
    AST_DROP_EV: assert property (@(posedge pclk) disable iff (!presetn)
        rx_fault |=> events[EV_DROP])
        else $error("dropped packet not recorded as event");
    AST_STICKY_ALL: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_status |=> ((status & $past(status)) == $past(status)))
        else $error("status flag lost without software clear");
    AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
        bus_setup |=> pready)
        else $error("setup cycle not answered in access phase");

endmodule

// ===== verif/vmf_requestor.sv
// Model of the on-chip requestors that report accesses and enqueue frames.
`timescale 1ns/10ps

module vmf_requestor
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Access reports and enqueued frames.
    output vmf_pkg::vmf_access_t acc,
    output vmf_pkg::vmf_frame_t frame_in
);
    import vmf_pkg::*;

    initial
    begin
        acc = '0;
        frame_in = '0;
    end

    // Reports one access for a single cycle, then leaves inverted stale fields.
    task automatic send(input vmf_access_t a);
        @(posedge pclk);
        acc <= a;
        @(posedge pclk);
        acc <= {1'b0, ~a[$bits(a)-2:0]};
    endtask

    // Enqueues one frame and holds off while the scheduler is busy.
    task automatic enqueue(input logic [15:0] fid, input logic failed);
        @(posedge pclk);
        frame_in <= '{valid: 1'b1, frame_id: fid, hdr_failed: failed};
        @(posedge pclk);
        frame_in <= '{valid: 1'b0, frame_id: ~fid, hdr_failed: ~failed};
        repeat (3) @(posedge pclk);
    endtask
endmodule

// ===== verif/virtual_memory_fault_status_test.sv
// Self-checking testbench of the virtual memory fault status block.
`timescale 1ns/10ps

module virtual_memory_fault_status_test;
    import vmf_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, r, e, bmax;
    logic seg_valid, free_valid, rx_drop, map_page, halt_read, irq;
    logic [15:0] seg_frame, free_frame, got_frame, fid;
    logic [4:0] seen;
    vmf_access_t acc, a;
    vmf_frame_t frame_in;
    logic [31:0] corner [6] = '{32'h0000ffff, 32'h00010000, 32'h0000001f,
                                32'h00000020, 32'h0000081f, 32'h00000000};
    int errors, checks_done, cyc;

    vmf_status #(.FRAMES(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc(acc),
        .frame_in(frame_in), .seg_valid(seg_valid), .seg_frame(seg_frame),
        .free_valid(free_valid), .free_frame(free_frame), .rx_drop(rx_drop),
        .map_page(map_page), .halt_read(halt_read), .irq(irq));

    vmf_requestor u_req (.pclk(pclk), .presetn(presetn), .acc(acc), .frame_in(frame_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Action pulses are caught on the falling edge, where they are settled and
    // never meet the clears that the main sequence makes on the rising edge.
    always @(negedge pclk)
    begin
        seen <= seen | {halt_read, map_page, rx_drop, free_valid, seg_valid};
        if (seg_valid || free_valid)
            got_frame <= seg_valid ? seg_frame : free_frame;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected action pulses {free, seg} for a failed frame under each control code.
    function automatic logic [31:0] expect_act(input int m);
        if (m == FAIL_SEND)
            return 32'h1;
        if (m == FAIL_FREE)
            return 32'h2;
        return 32'h0;
    endfunction

    function automatic logic [31:0] expect_stat(input vmf_access_t x, input logic [31:0] lim);
        logic [31:0] s;
        logic dma;
        s = '0;
        dma = (x.req == REQ_CACHE_DMA) || (x.req == REQ_REASSEMBLY);
        if (x.write && x.page_fault)
            s[dma ? BIT_WR_REC : BIT_WR_NONREC] = 1'b1;
        if (!x.write && (x.page_fault || x.predictive || (x.cached_reread &&
            x.be != FULL_WORD_BE && x.vaddr[10:0] < SEG_HEAD_BYTES[10:0])))
            s[BIT_RD_FAULT] = 1'b1;
        s[BIT_ABOVE_MAX] = x.vaddr > lim;
        s[BIT_OUT_MAP] = x.vaddr >= MAPSIZE_RESET;
        return s;
    endfunction

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] ad, input string name, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(name, q, exp);
    endtask

    task automatic fault(input vmf_req_t rq, input logic w, input logic [15:0] fid);
        a = '0;
        a.valid = 1'b1;
        a.req = rq;
        a.write = w;
        a.page_fault = 1'b1;
        a.be = FULL_WORD_BE;
        a.frame_id = fid;
        seen = '0;
        u_req.send(a);
        repeat (2) @(posedge pclk);
    endtask

    task automatic stop_test();
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        seen = '0;
        got_frame = '0;
        fid = '0;
        bmax = BUFMAX_RESET;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        r = 32'h84d7;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS, "status_reset", {15'h0, STAT_RESET});
        rd(ADDR_CTRL, "ctrl_reset", 32'h1);
        rd(ADDR_BUFMAX, "bufmax_reset", BUFMAX_RESET);
        rd(ADDR_MAPSIZE, "mapsize_reset", MAPSIZE_RESET);
        apb(1'b0, 12'h040, 32'h0);
        check("unmapped", {q[30:0], err}, 32'h1);
        for (int i = 0; i < 48; i++)
        begin
            r = lfsr(r);
            a = '0;
            a.valid = 1'b1;
            a.req = vmf_req_t'(r[1:0]);
            {a.cached_reread, a.predictive, a.page_fault, a.write} = r[5:2];
            a.be = r[9:6];
            a.vaddr = {15'h0, r[26:10]};
            if (i < 6)
            begin
                {a.cached_reread, a.predictive, a.page_fault, a.write} = 4'h8;
                a.vaddr = corner[i];
                a.be = (i == 5) ? FULL_WORD_BE : 4'h7;
            end
            if (i == 24)
            begin
                bmax = 32'h00007fff;
                apb(1'b1, ADDR_BUFMAX, bmax);
                rd(ADDR_BUFMAX, "bufmax_set", bmax);
            end
            e = expect_stat(a, bmax);
            apb(1'b1, ADDR_STATUS, {15'h0, STAT_IMPL});
            u_req.send(a);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check("status_wr", q & 32'h00000c00, e & 32'h00000c00);
            check("status_rd", q & 32'h00000200, e & 32'h00000200);
            check("status_lim", q & 32'hfffff1ff, e & 32'hfffff1ff);
            apb(1'b1, ADDR_STATUS, ~e & {15'h0, STAT_IMPL});
            rd(ADDR_STATUS, "status_kept", e);
        end
        fault(REQ_OTHER, 1'b0, 16'h0);
        check("read_map", {27'h0, seen}, 32'h08);
        apb(1'b1, ADDR_LOCK, 32'h200);
        fault(REQ_OTHER, 1'b0, 16'h0);
        check("read_halt", {27'h0, seen}, 32'h10);
        apb(1'b1, ADDR_LOCK, 32'h0);
        fault(REQ_REASSEMBLY, 1'b1, 16'h0);
        check("rx_drop", {27'h0, seen}, 32'h04);
        rd(ADDR_EVENT, "drop_event", 32'h6);
        for (int m = 0; m < 3; m++)
        begin
            fid = 16'h0011 + m[15:0];
            apb(1'b1, ADDR_EVENT, 32'h7);
            apb(1'b1, ADDR_CTRL, m);
            fault(REQ_CACHE_DMA, 1'b1, fid);
            seen = '0;
            u_req.enqueue(fid, 1'b0);
            check("failed_frame", {27'h0, seen}, expect_act(m));
            if (m != 2)
                check("act_frame", {16'h0, got_frame}, {16'h0, fid});
            rd(ADDR_EVENT, "sched_event", {31'h0, m == 2});
            seen = '0;
            u_req.enqueue(fid, 1'b0);
            check("clean_frame", {27'h0, seen}, 32'h1);
            check("seg_frame", {16'h0, got_frame}, {16'h0, fid});
        end
        apb(1'b1, ADDR_EVENT, 32'h7);
        seen = '0;
        u_req.enqueue(16'h0030, 1'b1);
        check("hdr_frame", {27'h0, seen}, 32'h0);
        rd(ADDR_EVENT, "hdr_event", 32'h1);
        apb(1'b1, ADDR_STATUS, {15'h0, STAT_IMPL});
        apb(1'b1, ADDR_EVENT, 32'h7);
        apb(1'b1, ADDR_MASK, 32'h800);
        fault(REQ_OTHER, 1'b1, 16'h0);
        check("irq_set", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h800);
        repeat (2) @(posedge pclk);
        check("irq_clear", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0);
        fault(REQ_SCHEDULER, 1'b1, 16'h0);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rd(ADDR_STATUS, "status_masked", 32'h800);
        stop_test();
    end
endmodule
